// ---- logic/special_flags_pkg.sv ----
package special_flags_pkg;
    localparam int unsigned clk_hz        = 100_000_000;
    localparam int unsigned ns_per_cycle  = 1_000_000_000 / clk_hz;
    // clock periods in milliseconds, in order 20ms..60s
    localparam int unsigned num_clocks    = 8;
    localparam int unsigned period_ms [num_clocks] = '{20, 100, 200, 1000, 2000, 10000, 20000, 60000};
    // one millisecond tick
    localparam int unsigned ms_cycles     = 1_000_000 / ns_per_cycle;
    localparam int unsigned num_user      = 8;
    localparam int unsigned duty_w        = 16;
    // register byte offsets
    localparam logic [11:0] off_ctrl      = 12'h000;
    localparam logic [11:0] off_flags     = 12'h004;
    localparam logic [11:0] off_status    = 12'h008;
    localparam logic [11:0] off_mask      = 12'h00c;
    localparam logic [11:0] off_clocks    = 12'h010;
    localparam logic [11:0] off_duty_base = 12'h020;
    // flag bit positions in off_flags
    localparam int unsigned b_op_err      = 0;
    localparam int unsigned b_zero        = 1;
    localparam int unsigned b_carry       = 2;
    localparam int unsigned b_mem_err     = 4;
    localparam int unsigned b_op_latch    = 5;
    localparam int unsigned b_cmp         = 8;
    // status event bits
    localparam int unsigned ev_op_err     = 0;
    localparam int unsigned ev_mem_err    = 1;
    localparam int unsigned ev_carry      = 2;
    localparam int unsigned num_events    = 3;
    localparam logic [31:0] reset_word    = 32'h0000_0000;
endpackage

// ---- logic/special_flag_relays.sv ----
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/100ps
// How it works
// - fast cycle clocks 20, 100, 200 ms
// - slow cycle clocks 1,2,10,20,60 s
// - operation error flag plus latched copy
// - flag on special module memory error
// - zero flag follows zero result
// - less flag set when s1 below s2
// - greater flag set when s1 above s2
// - carry flag set on arithmetic carry
// - user clocks hold each state programmed scans
module special_flag_relays #(
    parameter int unsigned ms_count = special_flags_pkg::ms_cycles,
    parameter int unsigned data_w   = 16
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              op_valid,
    input  wire logic              op_error,
    input  wire logic [data_w-1:0] op_result,
    input  wire logic              op_carry,
    input  wire logic              mem_access_error,
    input  wire logic              compare_instruction,
    input  wire logic [data_w-1:0] cmp_src1,
    input  wire logic [data_w-1:0] cmp_src2,
    input  wire logic              scan_end,
    output logic [7:0]             cycle_clock,
    output logic [7:0]             user_clock,
    output logic                   op_error_flag,
    output logic                   op_error_latch,
    output logic                   mem_error_flag,
    output logic                   zero_flag,
    output logic                   carry_flag,
    output logic                   cmp_less_flag,
    output logic                   cmp_less_equal_flag,
    output logic                   cmp_equal_flag,
    output logic                   cmp_greater_flag,
    output logic                   cmp_greater_equal_flag,
    output logic                   cmp_not_equal_flag,
    output logic                   irq
);
    localparam int unsigned ne = special_flags_pkg::num_events;
    localparam int unsigned nu = special_flags_pkg::num_user;
    localparam int unsigned dw = special_flags_pkg::duty_w;

    logic [31:0] ms_cnt, next_ms_cnt;
    logic        ms_tick, next_ms_tick;
    logic [31:0] half_cnt [8];
    logic [31:0] next_half_cnt [8];
    logic [7:0]  next_cycle_clock;

    // millisecond time base
    always_comb begin
        next_ms_tick = (ms_cnt == 32'(ms_count - 1));
        next_ms_cnt  = next_ms_tick ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
    end

    // each cycle clock toggles every half period
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            next_half_cnt[i]    = half_cnt[i];
            next_cycle_clock[i] = cycle_clock[i];
            if (ms_tick) begin
                if (half_cnt[i] == 32'(special_flags_pkg::period_ms[i] / 2 - 1)) begin
                    next_half_cnt[i]    = 32'h0000_0000;
                    next_cycle_clock[i] = ~cycle_clock[i];
                end else begin
                    next_half_cnt[i] = half_cnt[i] + 32'h0000_0001;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cnt      <= 32'h0000_0000;
            ms_tick     <= 1'b0;
            cycle_clock <= 8'h00;
            for (int i = 0; i < 8; i++) half_cnt[i] <= 32'h0000_0000;
        end else begin
            ms_cnt      <= next_ms_cnt;
            ms_tick     <= next_ms_tick;
            cycle_clock <= next_cycle_clock;
            for (int i = 0; i < 8; i++) half_cnt[i] <= next_half_cnt[i];
        end
    end

    // result and compare flags
    logic next_op_err, next_op_latch, next_mem_err, next_zero, next_carry;
    logic [5:0] next_cmp;
    logic       latch_clear;

    always_comb begin
        next_op_err   = op_error_flag;
        next_zero     = zero_flag;
        next_carry    = carry_flag;
        next_mem_err  = mem_access_error;
        next_op_latch = (op_error_latch & ~latch_clear) | (op_valid & op_error);
        next_cmp      = {cmp_not_equal_flag, cmp_greater_equal_flag, cmp_greater_flag,
                         cmp_equal_flag, cmp_less_equal_flag, cmp_less_flag};
        if (op_valid) begin
            next_op_err = op_error;
            next_zero   = (op_result == '0);
            next_carry  = op_carry;
        end
        if (compare_instruction) begin
            next_cmp[0] = cmp_src1 <  cmp_src2;
            next_cmp[3] = cmp_src1 >  cmp_src2;
            next_cmp[1] = cmp_src1 <= cmp_src2;
            next_cmp[2] = cmp_src1 == cmp_src2;
            next_cmp[4] = cmp_src1 >= cmp_src2;
            next_cmp[5] = cmp_src1 != cmp_src2;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_error_flag  <= 1'b0;
            op_error_latch <= 1'b0;
            mem_error_flag <= 1'b0;
            zero_flag      <= 1'b0;
            carry_flag     <= 1'b0;
            {cmp_not_equal_flag, cmp_greater_equal_flag, cmp_greater_flag,
             cmp_equal_flag, cmp_less_equal_flag, cmp_less_flag} <= 6'h00;
        end else begin
            op_error_flag  <= next_op_err;
            op_error_latch <= next_op_latch;
            mem_error_flag <= next_mem_err;
            zero_flag      <= next_zero;
            carry_flag     <= next_carry;
            {cmp_not_equal_flag, cmp_greater_equal_flag, cmp_greater_flag,
             cmp_equal_flag, cmp_less_equal_flag, cmp_less_flag} <= next_cmp;
        end
    end

    // user clocks counted in scans
    logic [dw-1:0] duty [nu];
    logic [dw-1:0] scan_cnt [nu];
    logic [dw-1:0] next_scan_cnt [nu];
    logic [7:0]    next_user_clock;

    always_comb begin
        for (int i = 0; i < nu; i++) begin
            next_scan_cnt[i]   = scan_cnt[i];
            next_user_clock[i] = user_clock[i];
            if (duty[i] == '0) begin
                next_scan_cnt[i]   = '0;
                next_user_clock[i] = 1'b0;
            end else if (scan_end) begin
                if (scan_cnt[i] >= duty[i] - dw'(1)) begin
                    next_scan_cnt[i]   = '0;
                    next_user_clock[i] = ~user_clock[i];
                end else begin
                    next_scan_cnt[i] = scan_cnt[i] + dw'(1);
                end
            end
        end
    end

    // apb slave, status and mask
    logic            wr_en, rd_en, addr_ok;
    logic [ne-1:0]   status, next_status, mask, next_mask, events;
    logic [dw-1:0]   next_duty [nu];
    logic [31:0]     next_prdata;
    logic            next_pready, next_pslverr, next_irq;

    always_comb begin
        // writes commit at the edge where the master samples pready high
        wr_en   = psel & penable & pwrite & pready;
        rd_en   = psel & penable & ~pwrite & ~pready;
        addr_ok = (paddr == special_flags_pkg::off_ctrl) || (paddr == special_flags_pkg::off_flags)
               || (paddr == special_flags_pkg::off_status) || (paddr == special_flags_pkg::off_mask)
               || (paddr == special_flags_pkg::off_clocks)
               || (paddr[11:5] == special_flags_pkg::off_duty_base[11:5] && paddr[1:0] == 2'b00);
        latch_clear = wr_en && paddr == special_flags_pkg::off_ctrl && pwdata[0];
        events = '0;
        events[special_flags_pkg::ev_op_err]  = op_valid & op_error;
        events[special_flags_pkg::ev_mem_err] = mem_access_error;
        events[special_flags_pkg::ev_carry]   = op_valid & op_carry;
        next_mask   = mask;
        next_status = status;
        for (int i = 0; i < nu; i++) next_duty[i] = duty[i];
        if (wr_en && paddr == special_flags_pkg::off_status) next_status = status & ~pwdata[ne-1:0];
        if (wr_en && paddr == special_flags_pkg::off_mask) next_mask = pwdata[ne-1:0];
        if (wr_en && paddr[11:5] == special_flags_pkg::off_duty_base[11:5] && paddr[1:0] == 2'b00)
            next_duty[paddr[4:2]] = pwdata[dw-1:0];
        next_status = next_status | events;
        next_prdata = special_flags_pkg::reset_word;
        if (rd_en) begin
            unique case (1'b1)
                paddr == special_flags_pkg::off_flags: begin
                    next_prdata[special_flags_pkg::b_op_err]   = op_error_flag;
                    next_prdata[special_flags_pkg::b_zero]     = zero_flag;
                    next_prdata[special_flags_pkg::b_carry]    = carry_flag;
                    next_prdata[special_flags_pkg::b_mem_err]  = mem_error_flag;
                    next_prdata[special_flags_pkg::b_op_latch] = op_error_latch;
                    next_prdata[special_flags_pkg::b_cmp +: 6] = {cmp_not_equal_flag, cmp_greater_equal_flag,
                        cmp_greater_flag, cmp_equal_flag, cmp_less_equal_flag, cmp_less_flag};
                end
                paddr == special_flags_pkg::off_status: next_prdata[ne-1:0] = status;
                paddr == special_flags_pkg::off_mask:   next_prdata[ne-1:0] = mask;
                paddr == special_flags_pkg::off_clocks: next_prdata[15:0] = {user_clock, cycle_clock};
                paddr[11:5] == special_flags_pkg::off_duty_base[11:5]: next_prdata[dw-1:0] = duty[paddr[4:2]];
                default: next_prdata = special_flags_pkg::reset_word;
            endcase
        end
        next_pready  = psel & penable & ~pready;
        next_pslverr = psel & penable & ~pready & ~addr_ok;
        next_irq     = |(next_status & next_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status     <= '0;
            mask       <= '0;
            prdata     <= 32'h0000_0000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            irq        <= 1'b0;
            user_clock <= 8'h00;
            for (int i = 0; i < nu; i++) begin
                duty[i]     <= '0;
                scan_cnt[i] <= '0;
            end
        end else begin
            status     <= next_status;
            mask       <= next_mask;
            prdata     <= next_prdata;
            pready     <= next_pready;
            pslverr    <= next_pslverr;
            irq        <= next_irq;
            user_clock <= next_user_clock;
            for (int i = 0; i < nu; i++) begin
                duty[i]     <= next_duty[i];
                scan_cnt[i] <= next_scan_cnt[i];
            end
        end
    end

    // checks
    property p_fast_toggle;
        @(posedge pclk) disable iff (!presetn)
        ms_tick && half_cnt[0] == 32'd9 |=> cycle_clock[0] != $past(cycle_clock[0]);
    endproperty
    a_fast_toggle: assert property (p_fast_toggle) else $error("20ms clock missed toggle");
    property p_slow_hold;
        @(posedge pclk) disable iff (!presetn)
        !ms_tick |=> $stable(cycle_clock[7:3]);
    endproperty
    a_slow_hold: assert property (p_slow_hold) else $error("slow clock changed off tick");
    property p_latch;
        @(posedge pclk) disable iff (!presetn)
        op_valid && op_error |=> op_error_flag && op_error_latch;
    endproperty
    a_latch: assert property (p_latch) else $error("op error not flagged");
    property p_mem;
        @(posedge pclk) disable iff (!presetn) mem_access_error |=> mem_error_flag && status[1];
    endproperty
    a_mem: assert property (p_mem) else $error("memory error not flagged");
    property p_zero;
        @(posedge pclk) disable iff (!presetn) op_valid |=> zero_flag == ($past(op_result) == '0);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    property p_less;
        @(posedge pclk) disable iff (!presetn)
        compare_instruction |=> cmp_less_flag == ($past(cmp_src1) < $past(cmp_src2));
    endproperty
    a_less: assert property (p_less) else $error("less flag wrong");
    property p_greater;
        @(posedge pclk) disable iff (!presetn)
        compare_instruction |=> cmp_greater_flag == ($past(cmp_src1) > $past(cmp_src2));
    endproperty
    a_greater: assert property (p_greater) else $error("greater flag wrong");
    property p_consistent;
        @(posedge pclk) disable iff (!presetn)
        compare_instruction |=> (cmp_equal_flag != cmp_not_equal_flag)
            && cmp_less_equal_flag == (cmp_less_flag | cmp_equal_flag)
            && cmp_greater_equal_flag == (cmp_greater_flag | cmp_equal_flag);
    endproperty
    a_consistent: assert property (p_consistent) else $error("compare flags inconsistent");
    property p_carry;
        @(posedge pclk) disable iff (!presetn) op_valid |=> carry_flag == $past(op_carry);
    endproperty
    a_carry: assert property (p_carry) else $error("carry flag wrong");
    property p_user;
        @(posedge pclk) disable iff (!presetn) !scan_end && duty[0] != '0 |=> $stable(user_clock[0]);
    endproperty
    a_user: assert property (p_user) else $error("user clock changed mid scan");
    c_cmp_eq: cover property (@(posedge pclk) compare_instruction && cmp_src1 == cmp_src2);
    c_irq:    cover property (@(posedge pclk) irq);
    c_user:   cover property (@(posedge pclk) $rose(user_clock[0]));
endmodule // special_flag_relays

// ---- verification/exec_model.sv ----
`timescale 1ns/100ps
module exec_model (
    input  wire logic        pclk,
    output logic             op_valid,
    output logic             op_error,
    output logic [15:0]      op_result,
    output logic             op_carry,
    output logic             mem_access_error,
    output logic             compare_instruction,
    output logic [15:0]      cmp_src1,
    output logic [15:0]      cmp_src2,
    output logic             scan_end
);
    initial begin
        {op_valid, op_error, op_carry, mem_access_error, compare_instruction, scan_end} = 6'h00;
        {op_result, cmp_src1, cmp_src2} = 48'h0;
    end
    // one result word, valid for a single cycle, then the data lines move on
    task automatic op(input logic err, input logic [15:0] res, input logic cy);
        @(posedge pclk);
        op_valid <= 1'b1;
        op_error <= err;
        op_result <= res;
        op_carry <= cy;
        @(posedge pclk);
        op_valid <= 1'b0;
        op_result <= ~res;
        op_carry <= !cy;
        @(negedge pclk);
    endtask
    task automatic cmp(input logic [15:0] a, input logic [15:0] b);
        @(posedge pclk);
        compare_instruction <= 1'b1;
        cmp_src1 <= a;
        cmp_src2 <= b;
        @(posedge pclk);
        compare_instruction <= 1'b0;
        cmp_src1 <= ~a;
        cmp_src2 <= ~b;
        @(negedge pclk);
    endtask
    // sel 0 pulses the memory error line, sel 1 the end of scan
    task automatic pulse(input logic sel);
        @(posedge pclk);
        mem_access_error <= !sel;
        scan_end <= sel;
        @(posedge pclk);
        mem_access_error <= 1'b0;
        scan_end <= 1'b0;
        @(negedge pclk);
    endtask
endmodule // exec_model

// ---- verification/plc_special_flag_relays_tb_top.sv ----
`timescale 1ns/100ps
module plc_special_flag_relays_tb_top;
    localparam int unsigned ms_n = 10;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slv, v;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        op_valid, op_error, op_carry, mem_access_error, compare_instruction, scan_end;
    logic        op_error_flag, op_error_latch, mem_error_flag, zero_flag, carry_flag;
    logic        cmp_less_flag, cmp_less_equal_flag, cmp_equal_flag;
    logic        cmp_greater_flag, cmp_greater_equal_flag, cmp_not_equal_flag;
    logic [15:0] op_result, cmp_src1, cmp_src2;
    logic [7:0]  cycle_clock, user_clock;
    logic [15:0] ca [4] = '{16'h0001, 16'h0002, 16'hffff, 16'h0000};
    logic [15:0] cb [4] = '{16'h0002, 16'h0002, 16'h0001, 16'hffff};
    int          err_total = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          n;

    special_flag_relays #(.ms_count(ms_n), .data_w(16)) DUT (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .op_valid, .op_error, .op_result, .op_carry, .mem_access_error, .compare_instruction,
        .cmp_src1, .cmp_src2, .scan_end, .cycle_clock, .user_clock, .op_error_flag, .op_error_latch,
        .mem_error_flag, .zero_flag, .carry_flag, .cmp_less_flag, .cmp_less_equal_flag, .cmp_equal_flag,
        .cmp_greater_flag, .cmp_greater_equal_flag, .cmp_not_equal_flag, .irq);
    exec_model MDL (.pclk, .op_valid, .op_error, .op_result, .op_carry, .mem_access_error,
        .compare_instruction, .cmp_src1, .cmp_src2, .scan_end);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic results();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            err_total = err_total + 1;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(special_flags_pkg::off_flags, 32'h0);
        MDL.op(1'b0, 16'h0000, 1'b1);
        rdchk(special_flags_pkg::off_flags, 32'h6);
        MDL.op(1'b1, 16'h0001, 1'b0);
        chk(op_error_flag, 1'b1);
        rdchk(special_flags_pkg::off_flags, 32'h21);
        MDL.op(1'b0, 16'h8000, 1'b0);
        rdchk(special_flags_pkg::off_flags, 32'h20);
        apb(1'b1, special_flags_pkg::off_ctrl, 32'h1);
        rdchk(special_flags_pkg::off_flags, 32'h0);
        MDL.pulse(1'b0);
        chk(mem_error_flag, 1'b1);
        $display("test flags done");
        rdchk(special_flags_pkg::off_status, 32'h7);
        chk(irq, 1'b0);
        apb(1'b1, special_flags_pkg::off_mask, 32'h7);
        repeat (2) @(negedge pclk);
        chk(irq, 1'b1);
        rdchk(special_flags_pkg::off_mask, 32'h7);
        apb(1'b1, special_flags_pkg::off_status, 32'h1);
        rdchk(special_flags_pkg::off_status, 32'h6);
        apb(1'b1, special_flags_pkg::off_status, 32'h6);
        rdchk(special_flags_pkg::off_status, 32'h0);
        repeat (2) @(negedge pclk);
        chk(irq, 1'b0);
        apb(1'b0, 12'h3fc, 32'h0);
        chk({31'h0, slv}, 32'h1);
        chk(rd, 32'h0);
        $display("test status and irq done");
        for (int i = 0; i < 4; i++) begin
            MDL.cmp(ca[i], cb[i]);
            rdchk(special_flags_pkg::off_flags, {18'h0, ca[i] != cb[i], ca[i] >= cb[i], ca[i] > cb[i],
                  ca[i] == cb[i], ca[i] <= cb[i], ca[i] < cb[i], 8'h0});
        end
        $display("test compare done");
        apb(1'b1, special_flags_pkg::off_duty_base, 32'h2);
        rdchk(special_flags_pkg::off_duty_base, 32'h2);
        v = user_clock[0];
        for (int k = 0; k < 4 && user_clock[0] === v; k++)
            MDL.pulse(1'b1);
        for (int k = 0; k < 3; k++) begin
            v = user_clock[0];
            MDL.pulse(1'b1);
            chk(user_clock[0], v);
            MDL.pulse(1'b1);
            chk(user_clock[0], !v);
        end
        chk(user_clock[7:1], 7'h00);
        $display("test user clock done");
        for (int j = 0; j < 5; j++) begin
            n = 0;
            while (cycle_clock[j] !== 1'b0) @(posedge pclk);
            while (cycle_clock[j] !== 1'b1) @(posedge pclk);
            while (cycle_clock[j] === 1'b1) begin
                @(posedge pclk);
                n++;
            end
            chk(n, ms_n * special_flags_pkg::period_ms[j] / 2);
        end
        chk(cycle_clock[7:6], 2'h0);
        $display("test cycle clocks done");
        results();
    end
endmodule // plc_special_flag_relays_tb_top
